// file: dsi_status_irq.sv
// status flag and interrupt logic of the decoder
// assumes conditions are synchronous to core_clk and the apb master follows the protocol
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dsi_status_irq (
    input wire logic core_clk,
    input wire logic rst,
    input wire dsi_pkg::dsi_cond_t cond,
    input wire dsi_pkg::dsi_apb_req_t apb_req,
    output dsi_pkg::dsi_apb_rsp_t apb_rsp,
    input wire logic irq_n_in,
    output logic irq_n_out,
    output logic irq_n_oe
);
    typedef struct packed {
        logic [3:0][7:0] flag;
        logic [3:0][7:0] mask;
        dsi_pkg::dsi_cond_t prev;
        logic primed;
        logic [31:0] rdata;
        logic slverr;
    } dsi_state_t;

    dsi_state_t st;
    dsi_state_t next_st;
    logic [3:0][7:0] trig;
    logic [3:0][7:0] live;
    logic access;
    logic [1:0] grp;
    logic pending;

    // pin level is unused: the pin only reports, it is never sampled
    logic unused_pin;
    assign unused_pin = irq_n_in;

    // edge detect on each live condition; the first cycle after reset only primes history
    always_comb begin
        trig = '0;
        live = '0;
        live[0][dsi_pkg::BIT_POWER_FAIL] = cond.power_fail;
        live[0][dsi_pkg::BIT_SCALER_ERR] = cond.scaler_err;
        live[1][dsi_pkg::BIT_INTERLACE] = cond.interlaced;
        live[1][dsi_pkg::BIT_HLOCK] = cond.hpll_locked;
        live[1][dsi_pkg::BIT_VLOCK] = cond.vlocked;
        live[1][dsi_pkg::BIT_FIELD_RATE] = cond.field_60hz;
        live[1][dsi_pkg::BIT_CAPTURE] = cond.capture_ready;
        live[2][dsi_pkg::BIT_COLOUR1:dsi_pkg::BIT_COLOUR0] = cond.colour_std;
        live[2][dsi_pkg::BIT_COPY_A] = cond.copy_a;
        live[2][dsi_pkg::BIT_COPY_B] = cond.copy_b;
        live[2][dsi_pkg::BIT_COPY_C] = cond.copy_c;
        live[3][dsi_pkg::BIT_VPS] = cond.vps_id;
        live[3][dsi_pkg::BIT_WIDESCREEN] = cond.widescreen_id;
        live[3][dsi_pkg::BIT_CAPTION] = cond.caption_id;
        if (st.primed) begin
            // power fail and scaler error are events on their rising edge only
            trig[0][dsi_pkg::BIT_POWER_FAIL] = cond.power_fail & ~st.prev.power_fail;
            trig[0][dsi_pkg::BIT_SCALER_ERR] = cond.scaler_err & ~st.prev.scaler_err;
            trig[1][dsi_pkg::BIT_INTERLACE] = cond.interlaced ^ st.prev.interlaced;
            trig[1][dsi_pkg::BIT_HLOCK] = cond.hpll_locked ^ st.prev.hpll_locked;
            trig[1][dsi_pkg::BIT_VLOCK] = cond.vlocked ^ st.prev.vlocked;
            trig[1][dsi_pkg::BIT_FIELD_RATE] = cond.field_60hz ^ st.prev.field_60hz;
            trig[1][dsi_pkg::BIT_CAPTURE] = cond.capture_ready ^ st.prev.capture_ready;
            // colour loss shows up as a change of the code too
            trig[2][dsi_pkg::BIT_COLOUR1:dsi_pkg::BIT_COLOUR0] =
                cond.colour_std ^ st.prev.colour_std;
            trig[2][dsi_pkg::BIT_COPY_A] = cond.copy_a ^ st.prev.copy_a;
            trig[2][dsi_pkg::BIT_COPY_B] = cond.copy_b ^ st.prev.copy_b;
            trig[2][dsi_pkg::BIT_COPY_C] = cond.copy_c ^ st.prev.copy_c;
            trig[3][dsi_pkg::BIT_VPS] = cond.vps_id ^ st.prev.vps_id;
            trig[3][dsi_pkg::BIT_WIDESCREEN] = cond.widescreen_id ^ st.prev.widescreen_id;
            trig[3][dsi_pkg::BIT_CAPTION] = cond.caption_id ^ st.prev.caption_id;
        end
    end

    // one wait state slave: register effects (mask write, flag clear, read capture)
    // happen once, in the first access cycle; the second cycle only answers, so a
    // read can never clear a flag twice or return flags it has already cleared
    logic data_ok;
    logic act;
    logic aligned;
    assign access = apb_req.psel & apb_req.penable;
    assign act = access & ~data_ok;
    assign aligned = (apb_req.paddr[1:0] == 2'h0);
    assign grp = apb_req.paddr[3:2];

    // next state: flags, masks and read data
    always_comb begin
        next_st = st;
        next_st.prev = cond;
        next_st.primed = 1'b1;
        for (int g = 0; g < dsi_pkg::NUM_GRP; g++) begin
            // set wins over the clearing read of the same register
            if (act && aligned && !apb_req.pwrite
                && apb_req.paddr[11:4] == dsi_pkg::OFS_FLAG0[11:4] && grp == g[1:0]) begin
                next_st.flag[g] = trig[g];
            end else begin
                next_st.flag[g] = st.flag[g] | trig[g];
            end
        end
        if (act) begin
            next_st.slverr = 1'b0;
            next_st.rdata = '0;
            unique case (apb_req.paddr[11:4])
                dsi_pkg::OFS_FLAG0[11:4]: begin
                    next_st.rdata = {24'h000000, st.flag[grp]};
                end
                dsi_pkg::OFS_MASK0[11:4]: begin
                    next_st.rdata = {24'h000000, st.mask[grp]};
                    // a misaligned write is refused and leaves the masks alone
                    if (apb_req.pwrite && aligned) begin
                        next_st.mask[grp] = apb_req.pwdata[7:0];
                    end
                end
                dsi_pkg::OFS_LIVE0[11:4]: begin
                    next_st.rdata = {24'h000000, live[grp]};
                end
                default: begin
                    next_st.slverr = 1'b1;
                end
            endcase
            if (apb_req.paddr[1:0] != 2'h0) begin
                next_st.slverr = 1'b1;
            end
        end
    end

    // single register stage for all state but data_ok
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st.flag <= {4{dsi_pkg::FLAG_RST}};
            st.mask <= {4{dsi_pkg::MASK_RST}};
            st.prev <= '0;
            st.primed <= 1'b0;
            st.rdata <= 32'h00000000;
            st.slverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // read data is taken at the first access edge; pready rises one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_ok <= 1'b0;
        end else begin
            data_ok <= access & ~data_ok;
        end
    end

    // gate next_st only when data_ok is low so a two cycle access acts once
    assign apb_rsp.pready = data_ok;
    assign apb_rsp.prdata = st.rdata;
    assign apb_rsp.pslverr = st.slverr & data_ok;

    // open drain pin: drive low while any enabled flag is pending
    assign pending = |(st.flag & st.mask);
    assign irq_n_out = 1'b0;
    assign irq_n_oe = ~pending;

    // steps of an access: the effect edge, then the answer edge
    sequence s_first_access;
        act && aligned;
    endsequence

    // clearing read of one status register, at its effect edge
    sequence s_read_flag(int g);
        act && aligned && !apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_FLAG0[11:4]
            && grp == g[1:0];
    endsequence

    // mask write at its effect edge
    sequence s_write_mask;
        act && aligned && apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_MASK0[11:4];
    endsequence

    // read of a live state register at its effect edge
    sequence s_read_live;
        act && aligned && !apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_LIVE0[11:4];
    endsequence

    // read of any status register at its effect edge
    sequence s_read_status;
        act && aligned && !apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_FLAG0[11:4];
    endsequence

    // answer one cycle after the effect edge
    sequence s_answer;
        s_first_access ##1 apb_rsp.pready;
    endsequence

    // masks start cleared
    AST_MASK_RESET: assert property (@(posedge core_clk) $rose(st.primed) |-> st.mask == '0)
        else $error("masks not cleared after reset");

    // pin follows the masked flags exactly
    AST_IRQ_PIN: assert property (@(posedge core_clk) disable iff (rst)
        (irq_n_oe == 1'b0) == (|(st.flag & st.mask)))
        else $error("interrupt pin does not follow masked flags");

    // open drain: only ever drives low
    AST_PIN_LOW: assert property (@(posedge core_clk) disable iff (rst)
        irq_n_out == 1'b0)
        else $error("open drain pin drives high");

    // pin released right after reset since no mask is set yet
    AST_IRQ_RESET: assert property (@(posedge core_clk) disable iff (rst)
        $rose(st.primed) |-> irq_n_oe == 1'b1)
        else $error("interrupt pin pulled low after reset");

    AST_HLOCK_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.hpll_locked) |=> st.flag[1][dsi_pkg::BIT_HLOCK])
        else $error("hpll lock change not flagged");

    AST_VPS_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.vps_id) |=> st.flag[3][dsi_pkg::BIT_VPS])
        else $error("vps change not flagged");

    AST_IL_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.interlaced) |=> st.flag[1][dsi_pkg::BIT_INTERLACE])
        else $error("interlace change not flagged");

    AST_VLOCK_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.vlocked) |=> st.flag[1][dsi_pkg::BIT_VLOCK])
        else $error("vertical lock change not flagged");

    AST_FIELD_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.field_60hz) |=> st.flag[1][dsi_pkg::BIT_FIELD_RATE])
        else $error("field rate change not flagged");

    AST_CAPTURE_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.capture_ready) |=> st.flag[1][dsi_pkg::BIT_CAPTURE])
        else $error("capture ready change not flagged");

    // any change of the colour code leaves at least one of its two flags set
    AST_COLOUR_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.colour_std)
        |=> st.flag[2][dsi_pkg::BIT_COLOUR1:dsi_pkg::BIT_COLOUR0] != 2'h0)
        else $error("colour standard change not flagged");

    AST_COPY_A_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.copy_a) |=> st.flag[2][dsi_pkg::BIT_COPY_A])
        else $error("copy protection a change not flagged");

    AST_COPY_B_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.copy_b) |=> st.flag[2][dsi_pkg::BIT_COPY_B])
        else $error("copy protection b change not flagged");

    AST_COPY_C_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.copy_c) |=> st.flag[2][dsi_pkg::BIT_COPY_C])
        else $error("copy protection c change not flagged");

    AST_WIDE_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.widescreen_id) |=> st.flag[3][dsi_pkg::BIT_WIDESCREEN])
        else $error("widescreen change not flagged");

    AST_CAPTION_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $changed(cond.caption_id) |=> st.flag[3][dsi_pkg::BIT_CAPTION])
        else $error("caption change not flagged");

    // scaler error is an event on its rising edge only
    AST_SCALER_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $rose(cond.scaler_err) |=> st.flag[0][dsi_pkg::BIT_SCALER_ERR])
        else $error("scaler error not flagged");

    AST_POWER_SET: assert property (@(posedge core_clk) disable iff (rst)
        st.primed && $rose(cond.power_fail) |=> st.flag[0][dsi_pkg::BIT_POWER_FAIL])
        else $error("power fail not flagged");

    // a flag only rises when a trigger was seen on the edge before
    AST_NO_SPURIOUS: assert property (@(posedge core_clk) disable iff (rst)
        (st.flag & ~$past(st.flag)) == (st.flag & ~$past(st.flag) & $past(trig)))
        else $error("flag set without a trigger");

    // history register tracks the conditions one cycle behind
    AST_PREV_TRACK: assert property (@(posedge core_clk) disable iff (rst)
        st.primed |-> st.prev == $past(cond))
        else $error("condition history out of step");

    AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
        s_read_flag(1) and (trig[1] != 8'h00) |=> (st.flag[1] & $past(trig[1])) == $past(trig[1]))
        else $error("new trigger lost on clearing read");

    AST_OTHER_KEPT: assert property (@(posedge core_clk) disable iff (rst)
        s_read_flag(0) |=> (st.flag[2] & $past(st.flag[2])) == $past(st.flag[2]))
        else $error("flag cleared by read of another register");

    AST_CLEAR_READ: assert property (@(posedge core_clk) disable iff (rst)
        s_read_flag(3) and trig[3] == 8'h00 |=> st.flag[3] == 8'h00)
        else $error("flag not cleared by its own read");

    // flags never fall unless a status register is read
    AST_FLAG_KEEP: assert property (@(posedge core_clk) disable iff (rst)
        !(act && aligned && !apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_FLAG0[11:4])
        |=> (st.flag & $past(st.flag)) == $past(st.flag))
        else $error("flag cleared without a status read");

    // status read returns the flags as they stood before the clear
    AST_FLAG_READ: assert property (@(posedge core_clk) disable iff (rst)
        s_read_status |=> st.rdata == {24'h000000, $past(st.flag[grp])})
        else $error("status read data wrong");

    // live read returns the conditions of the effect edge
    AST_LIVE_READ: assert property (@(posedge core_clk) disable iff (rst)
        s_read_live |=> st.rdata == {24'h000000, $past(live[grp])})
        else $error("live read data wrong");

    AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_write_mask |=> st.mask[$past(grp)] == $past(apb_req.pwdata[7:0]))
        else $error("mask write lost");

    // masks change only through an aligned mask write
    AST_MASK_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !(act && aligned && apb_req.pwrite && apb_req.paddr[11:4] == dsi_pkg::OFS_MASK0[11:4])
        |=> st.mask == $past(st.mask))
        else $error("mask changed without a write");

    // each group reaches the pin through its own mask only
    AST_GRP0_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        (st.flag[0] & st.mask[0]) != 8'h00 |-> irq_n_oe == 1'b0)
        else $error("group 0 enabled flag does not pull the pin");

    AST_GRP1_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        (st.flag[1] & st.mask[1]) != 8'h00 |-> irq_n_oe == 1'b0)
        else $error("group 1 enabled flag does not pull the pin");

    AST_GRP2_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        (st.flag[2] & st.mask[2]) != 8'h00 |-> irq_n_oe == 1'b0)
        else $error("group 2 enabled flag does not pull the pin");

    AST_GRP3_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        (st.flag[3] & st.mask[3]) != 8'h00 |-> irq_n_oe == 1'b0)
        else $error("group 3 enabled flag does not pull the pin");

    // every access is answered exactly one cycle after its effect edge
    AST_READY_WAIT: assert property (@(posedge core_clk) disable iff (rst)
        act |=> apb_rsp.pready)
        else $error("access not answered after one wait state");

    AST_READY_PULSE: assert property (@(posedge core_clk) disable iff (rst)
        s_answer |=> !apb_rsp.pready)
        else $error("pready held longer than one cycle");

    // error only travels with the answer
    AST_PSLVERR_QUAL: assert property (@(posedge core_clk) disable iff (rst)
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");

    AST_ERR_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
        act && apb_req.paddr[11:4] > dsi_pkg::OFS_LIVE0[11:4] |=> st.slverr)
        else $error("unmapped access not refused");

    AST_ERR_ALIGN: assert property (@(posedge core_clk) disable iff (rst)
        act && !aligned |=> st.slverr)
        else $error("misaligned access not refused");

    // registers are eight bits wide; the upper bits always read zero
    AST_RDATA_UPPER: assert property (@(posedge core_clk) disable iff (rst)
        st.rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    // read data stands until the next access
    AST_RDATA_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !act |=> st.rdata == $past(st.rdata))
        else $error("read data changed outside an access");
endmodule
`default_nettype wire

// file: dsi_pkg.sv
// package for the decoder status interrupt block: register map, field layout, carriers
// assumes an apb slave with 32-bit data; registers are one aligned word each
//
// Notes on behaviour
// - interrupt pin is open drain, pulled low while anything is pending
// - every flag has its own mask enable bit
// - all mask enables are cleared by reset
// - power fail during operation sets a flag asking for reprogramming
// - interlace detection result change sets the interlace flag
// - horizontal pll lock change either way sets a flag
// - vertical lock change either way sets a flag
// - field rate switch between 50 and 60 hz sets a flag
// - ready for capture toggling sets a flag
// - colour standard change or colour loss sets a two bit field
// - three copy protection indications each set a flag on change
// - vps identification found or lost sets a flag
// - widescreen identification found or lost sets a flag
// - closed caption identification found or lost sets a flag
// - scaler output formatting error sets a flag
// - live state reads show live condition state, not a frozen snapshot
// - flags sit in four eight bit status registers
// - a flag clears only when its own status register is read
// - a trigger in the same cycle as the clearing read keeps the flag
package dsi_pkg;
    localparam int unsigned NUM_GRP = 4;
    // byte offsets: flags, masks, live state
    localparam logic [11:0] OFS_FLAG0 = 12'h000;
    localparam logic [11:0] OFS_MASK0 = 12'h010;
    localparam logic [11:0] OFS_LIVE0 = 12'h020;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h00;
    // group 0: power and scaler
    localparam int unsigned BIT_POWER_FAIL = 0;
    localparam int unsigned BIT_SCALER_ERR = 1;
    // group 1: decoder timing
    localparam int unsigned BIT_INTERLACE = 0;
    localparam int unsigned BIT_HLOCK = 1;
    localparam int unsigned BIT_VLOCK = 2;
    localparam int unsigned BIT_FIELD_RATE = 3;
    localparam int unsigned BIT_CAPTURE = 4;
    // group 2: colour and copy protection
    localparam int unsigned BIT_COLOUR0 = 0;
    localparam int unsigned BIT_COLOUR1 = 1;
    localparam int unsigned BIT_COPY_A = 2;
    localparam int unsigned BIT_COPY_B = 3;
    localparam int unsigned BIT_COPY_C = 4;
    // group 3: vbi slicer
    localparam int unsigned BIT_VPS = 0;
    localparam int unsigned BIT_WIDESCREEN = 1;
    localparam int unsigned BIT_CAPTION = 2;

    // live conditions from the decoder core
    typedef struct packed {
        logic power_fail;
        logic scaler_err;
        logic interlaced;
        logic hpll_locked;
        logic vlocked;
        logic field_60hz;
        logic capture_ready;
        logic [1:0] colour_std;
        logic copy_a;
        logic copy_b;
        logic copy_c;
        logic vps_id;
        logic widescreen_id;
        logic caption_id;
    } dsi_cond_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dsi_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dsi_apb_rsp_t;
endpackage

// file: dsi_irq_line.sv
// host side of the shared interrupt wire: pull-up plus open-drain drive
// assumes the block drives irq_n_out low whenever irq_n_oe is low
`timescale 1ns/100ps
`default_nettype none
module dsi_irq_line (
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    output logic irq_pin
);
    // released line floats up, so no stale drive value leaks through
    assign irq_pin = irq_n_oe ? 1'b1 : irq_n_out;
endmodule
`default_nettype wire

// file: decoder_status_interrupt_logic_tb.sv
// self-checking bench for dsi_status_irq with a flag and mask model
// assumes one 100 MHz clock and an apb slave with one wait state
`timescale 1ns/100ps
`default_nettype none
module decoder_status_interrupt_logic_tb;
    logic core_clk, rst, pin, flip;
    dsi_pkg::dsi_cond_t cond, prv;
    dsi_pkg::dsi_apb_req_t rq;
    dsi_pkg::dsi_apb_rsp_t rs;
    logic [31:0] flg, msk, clr, ex, rdat, rng;
    logic err, eer, hv, ti;
    int num_errors, compares, cyc;
    dsi_status_irq i_dsi_status_irq (.core_clk(core_clk), .rst(rst), .cond(cond),
        .apb_req(rq), .apb_rsp(rs), .irq_n_in(pin), .irq_n_out(ti), .irq_n_oe(hv));
    logic hs;
    dsi_irq_line i_dsi_irq_line (.irq_n_out(ti), .irq_n_oe(hv), .irq_pin(pin));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] live(dsi_pkg::dsi_cond_t c);
        live = 32'h0;
        live[1:0] = {c.scaler_err, c.power_fail};
        live[12:8] = {c.capture_ready, c.field_60hz, c.vlocked, c.hpll_locked, c.interlaced};
        live[20:16] = {c.copy_c, c.copy_b, c.copy_a, c.colour_std};
        live[26:24] = {c.caption_id, c.widescreen_id, c.vps_id};
    endfunction
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // reference model: supply and scaler flags on rising edge, the rest on any change
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flg <= 32'h0;
            msk <= 32'h0;
            hs <= 1'b0;
        end else begin
            clr = 32'h0;
            // effects land at the first access edge, the one before pready is high
            if (rq.psel && rq.penable && !rs.pready && rq.paddr[1:0] == 2'h0) begin
                if (!rq.pwrite && rq.paddr[11:4] == 8'h00) clr = 32'hFF << (8 * rq.paddr[3:2]);
                if (rq.pwrite && rq.paddr[11:4] == 8'h01) msk[8 * rq.paddr[3:2] +: 8] <= rq.pwdata[7:0];
            end
            // set wins over the clearing read of the same edge
            flg <= (flg & ~clr) | (hs ? (((live(prv) ^ live(cond)) & 32'hFFFFFFFC)
                | (live(cond) & ~live(prv) & 32'h3)) : 32'h0);
            hs <= 1'b1;
        end
        prv <= cond;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // apb transfer; flip toggles a condition so it triggers on the effect edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        rq.psel <= 1'b1;
        rq.pwrite <= w;
        rq.paddr <= a;
        rq.pwdata <= d;
        @(posedge core_clk);
        rq.penable <= 1'b1;
        // a toggle here triggers at the same edge as the clearing read
        if (flip) cond.interlaced <= ~cond.interlaced;
        flip = 1'b0;
        @(posedge core_clk);
        // expected data is what stands at the effect edge, before it updates
        eer = a[1:0] != 2'h0 || a[11:6] != 6'h0 || a[5:4] == 2'h3;
        case (a[5:4])
            2'h0: ex = flg >> (8 * a[3:2]);
            2'h1: ex = msk >> (8 * a[3:2]);
            default: ex = live(cond) >> (8 * a[3:2]);
        endcase
        while (rs.pready !== 1'b1) @(posedge core_clk);
        rdat = rs.prdata;
        err = rs.pslverr;
        rq.psel <= 1'b0;
        rq.penable <= 1'b0;
        @(posedge core_clk);
        chk("pslverr", {31'h0, eer}, {31'h0, err});
        if (!w && !eer) chk("prdata", ex & 32'hFF, rdat);
    endtask
    task automatic irq_chk();
        repeat (2) @(posedge core_clk);
        chk("irq pin", {31'h0, ~|(flg & msk)}, {31'h0, pin});
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 8000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        rq = '0;
        cond = '0;
        flip = 1'b0;
        rng = 32'h9E9FF59A;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int g = 0; g < 4; g++) apb(1'b0, 12'h010 + 12'(4 * g), 32'h0);
        irq_chk();
        for (int i = 0; i < 60; i++) begin
            rng = xs(rng);
            cond <= rng[14:0];
            irq_chk();
            if (rng[20]) apb(1'b1, 12'h010 + 12'(4 * rng[17:16]), {24'h0, rng[31:24]});
            irq_chk();
            flip = rng[21] && rng[19:18] == 2'h1;
            apb(1'b0, 12'(4 * rng[19:18]), 32'h0);
            irq_chk();
            apb(1'b0, 12'h020 + 12'(4 * rng[23:22]), 32'h0);
            apb(1'b0, 12'h010 + 12'(4 * rng[23:22]), 32'h0);
        end
        apb(1'b0, 12'h030, 32'h0);
        apb(1'b1, 12'h011, 32'hFF);
        irq_chk();
        test_done();
    end
endmodule
`default_nettype wire
